// file: sim/cpa_link_model.sv
/*
  Far side model: client link status, frame reports and peer events.
  Assumes tb_top drives it through its tasks, one at a time.
*/
`timescale 1ns/1ps
module cpa_link_model (
  input wire logic i_clk,
  output logic o_los,
  output logic o_outage,
  output logic o_far_auth,
  output logic o_frame_end,
  output logic [13:0] o_frame_len,
  output logic o_auth_error,
  output logic o_mismatch
);
  initial begin
    o_los = 1'b0;
    o_outage = 1'b0;
    o_far_auth = 1'b0;
    o_frame_end = 1'b0;
    o_frame_len = 14'h0000;
    o_auth_error = 1'b0;
    o_mismatch = 1'b0;
  end

  task set_link(input logic loss_of_input_signal, input logic outage, input logic far);
    @(posedge i_clk);
    o_los <= loss_of_input_signal;
    o_outage <= outage;
    o_far_auth <= far;
  endtask : set_link

  // Length not held once the report is over
  task frame(input logic [13:0] len);
    @(posedge i_clk);
    o_frame_end <= 1'b1;
    o_frame_len <= len;
    @(posedge i_clk);
    o_frame_end <= 1'b0;
    o_frame_len <= ~len;
  endtask : frame

  // one pulse per error or mismatch
  task pulse(input logic mis, input int n);
    repeat (n) begin
      @(posedge i_clk);
      o_mismatch <= mis;
      o_auth_error <= !mis;
      @(posedge i_clk);
      o_mismatch <= 1'b0;
      o_auth_error <= 1'b0;
    end
  endtask : pulse
endmodule : cpa_link_model

// file: sim/cpa_top_asserts.sv
/*
  Port checker for cpa_top, bound to every instance.
  Assumes i_ce stays high and link levels settle within a few cycles.
*/
`timescale 1ns/1ps
module cpa_top_asserts (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic [31:0] o_wb_dat,
  input wire logic o_wb_ack,
  input wire logic i_loss_of_input_signal,
  input wire logic i_traffic_outage,
  input wire logic i_far_auth_enable,
  input wire logic i_frame_end,
  input wire logic [13:0] i_frame_len,
  input wire logic o_frame_accept,
  input wire logic o_frame_discard,
  input wire logic o_laser_on,
  input wire logic o_auth_alarm
);
  logic [3:0] bad_age_q;
  logic [3:0] bad_age_d;

  // Cycles since the last outage or signal loss
  always_comb begin
    bad_age_d = bad_age_q;
    if (i_loss_of_input_signal || i_traffic_outage) begin
      bad_age_d = 4'h0;
    end else if (bad_age_q != 4'hF) begin
      bad_age_d = bad_age_q + 4'h1;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      bad_age_q <= 4'hF;
    end else begin
      bad_age_q <= bad_age_d;
    end
  end

  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  sequence s_req;
    i_ce && i_wb_cyc && i_wb_stb && !o_wb_ack;
  endsequence
  sequence s_ans;
    o_wb_ack ##1 !o_wb_ack;
  endsequence

  property p_ack_lat;
    s_req |=> s_ans;
  endproperty
  property p_dat_idle;
    !o_wb_ack |-> o_wb_dat == 32'h0000_0000;
  endproperty
  property p_frame_one;
    i_ce && i_frame_end |=> o_frame_accept != o_frame_discard;
  endproperty
  property p_frame_quiet;
    !i_frame_end |=> !o_frame_accept && !o_frame_discard;
  endproperty
  property p_len_hi;
    i_ce && i_frame_end && i_frame_len > 14'h25E4 |=> o_frame_discard;
  endproperty
  property p_len_lo;
    i_ce && i_frame_end && i_frame_len <= 14'h0040 |=> o_frame_accept;
  endproperty
  property p_laser_cause;
    $fell(o_laser_on) |-> bad_age_q < 4'h8;
  endproperty
  property p_alarm_far;
    $fell(i_far_auth_enable) |-> ##[1:6] !o_auth_alarm;
  endproperty

  a_ack_lat: assert property (p_ack_lat)
    else $error("ack not one cycle after request");
  a_dat_idle: assert property (p_dat_idle)
    else $error("read data nonzero outside ack");
  a_frame_one: assert property (p_frame_one)
    else $error("frame not accepted or discarded once");
  a_frame_quiet: assert property (p_frame_quiet)
    else $error("frame verdict without frame end");
  a_len_hi: assert property (p_len_hi)
    else $error("frame above largest size not discarded");
  a_len_lo: assert property (p_len_lo)
    else $error("frame at smallest size not accepted");
  a_laser_cause: assert property (p_laser_cause)
    else $error("laser off without outage or signal loss");
  a_alarm_far: assert property (p_alarm_far)
    else $error("auth alarm kept with far end disabled");
endmodule : cpa_top_asserts

bind cpa_top cpa_top_asserts cpa_top_asserts_inst (
  .i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(i_ce), .i_wb_cyc(i_wb_cyc),
  .i_wb_stb(i_wb_stb), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack),
  .i_loss_of_input_signal(i_loss_of_input_signal),
  .i_traffic_outage(i_traffic_outage),
  .i_far_auth_enable(i_far_auth_enable), .i_frame_end(i_frame_end),
  .i_frame_len(i_frame_len), .o_frame_accept(o_frame_accept),
  .o_frame_discard(o_frame_discard), .o_laser_on(o_laser_on),
  .o_auth_alarm(o_auth_alarm)
);

// file: sim/tb_top.sv
/*
  Self-checking bench for cpa_top over classic Wishbone.
  Assumes short soak step and auth window parameters.
*/
`timescale 1ns/1ps
module tb_top;
  import cpa_pkg::*;
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h0000_0000;
  logic [31:0] rdat;
  logic ack, loss_of_input_signal, outage, far, fend, facc, fdis, aerr, mis;
  logic laser, alarm, irq;
  logic [13:0] flen;
  cpa_svc_type svc;
  logic [31:0] q;
  logic [31:0] wr [4] = '{32'h0000_060C, 32'h0000_0064, 32'h0000_0014,
    32'h0000_270F};
  logic [31:0] eff [4] = '{32'h0000_060C, 32'h0000_0064, 32'h0000_0040,
    32'h0000_25E4};
  int err_total = 0;
  int tests_run = 0;
  int n;

  always #4 i_clk = ~i_clk;

  cpa_top #(.SOAK_STEP_CYC(64'd20), .AUTH_WIN_CYC(64'd50)) cpa_top_inst (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(1'b1), .i_wb_cyc(cyc),
    .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hF),
    .i_wb_dat(dat), .o_wb_dat(rdat), .o_wb_ack(ack),
    .i_loss_of_input_signal(loss_of_input_signal), .i_traffic_outage(outage),
    .i_far_auth_enable(far), .i_frame_end(fend), .i_frame_len(flen),
    .o_frame_accept(facc), .o_frame_discard(fdis), .i_auth_error(aerr),
    .i_packet_sequence_number_mismatch(mis), .o_laser_on(laser),
    .o_service_state(svc), .o_auth_alarm(alarm), .o_irq(irq));

  cpa_link_model cpa_link_model_inst (
    .i_clk(i_clk), .o_los(loss_of_input_signal), .o_outage(outage), .o_far_auth(far),
    .o_frame_end(fend), .o_frame_len(flen), .o_auth_error(aerr),
    .o_mismatch(mis));

  task give_verdict;
    if (err_total == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : give_verdict

  task chk(input string s, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", s, e, g);
      err_total++;
    end
  endtask : chk

  task tmo(input int k);
    if (k >= 200) begin
      $display("[FAIL] wait expected done seen timeout");
      err_total++;
      give_verdict();
    end
  endtask : tmo

  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge i_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    k = 0;
    do begin
      @(posedge i_clk);
      k++;
    end while (ack !== 1'b1 && k < 200);
    tmo(k);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : xfer

  task frm(input logic [13:0] l, input logic e);
    cpa_link_model_inst.frame(l);
    @(posedge i_clk);
    chk("frame_accept", 32'(e), 32'(facc));
    chk("frame_discard", 32'(!e), 32'(fdis));
  endtask : frm

  task wait_alarm;
    for (n = 0; n < 200 && alarm !== 1'b1; n++) @(posedge i_clk);
    tmo(n);
  endtask : wait_alarm

  initial begin
    repeat (20) @(posedge i_clk);
    i_rst_n <= 1'b1;
    repeat (8) @(posedge i_clk);
    xfer(0, REG_CTRL, 0); chk("ctrl", 32'h0000_0010, q);
    xfer(0, REG_SOAK, 0); chk("soak", 32'h0000_0000, q);
    xfer(0, 8'h3C, 0); chk("unmapped", 32'h0000_0000, q);
    xfer(0, REG_AUTH_THR, 0); chk("thr_reset", 32'h0000_0001, q);
    for (int i = 0; i < 4; i++) begin
      if (i > 0) xfer(1, REG_MAX_FRAME, wr[i]);
      xfer(0, REG_MAX_FRAME, 0); chk("max_frame", eff[i], q);
      frm(eff[i][13:0], 1'b1);
      frm(eff[i][13:0] + 14'h0001, 1'b0);
    end
    xfer(0, REG_OVERSIZE_CNT, 0); chk("oversize", 32'h0000_0004, q);
    xfer(1, REG_CTRL, 32'h0000_0000);
    xfer(1, REG_MAX_FRAME, 32'h0000_00C8);
    xfer(0, REG_MAX_FRAME, 0); chk("max_locked", 32'h0000_25E4, q);
    xfer(1, REG_AUTH_THR, 0);
    xfer(0, REG_AUTH_THR, 0); chk("thr_min", 32'h0000_0001, q);
    xfer(1, REG_AUTH_THR, 32'h0000_0258);
    xfer(0, REG_AUTH_THR, 0); chk("thr_max", 32'h0000_01F4, q);
    cpa_link_model_inst.set_link(1, 0, 0);
    repeat (8) @(posedge i_clk);
    chk("laser_dis", 32'h1, 32'(laser));
    cpa_link_model_inst.set_link(0, 0, 0);
    xfer(1, REG_IRQ_CLEAR, 32'h0000_001F);
    xfer(1, REG_CTRL, 32'h0000_0011);
    cpa_link_model_inst.set_link(0, 1, 0);
    repeat (8) @(posedge i_clk);
    chk("laser_out", 32'h0, 32'(laser));
    cpa_link_model_inst.set_link(0, 0, 0);
    repeat (8) @(posedge i_clk);
    chk("laser_hold", 32'h0, 32'(laser));
    chk("irq_masked", 32'h0, 32'(irq));
    xfer(1, REG_IRQ_ENABLE, 32'h0000_0001);
    repeat (2) @(posedge i_clk);
    chk("irq_on", 32'h1, 32'(irq));
    xfer(1, REG_IRQ_CLEAR, 32'h0000_0001);
    repeat (2) @(posedge i_clk);
    chk("irq_clr", 32'h0, 32'(irq));
    xfer(1, REG_CTRL, 32'h0000_0015);
    repeat (2) @(posedge i_clk);
    chk("laser_restart", 32'h1, 32'(laser));
    cpa_link_model_inst.set_link(1, 0, 0);
    repeat (8) @(posedge i_clk);
    chk("laser_los", 32'h0, 32'(laser));
    xfer(1, REG_CTRL, 32'h0000_0012);
    repeat (2) @(posedge i_clk);
    chk("laser_test", 32'h1, 32'(laser));
    cpa_link_model_inst.set_link(0, 0, 0);
    xfer(1, REG_SOAK, 32'h0000_00FF);
    xfer(0, REG_SOAK, 0); chk("soak_max", 32'h0000_00C0, q);
    xfer(1, REG_SOAK, 32'h0000_0001);
    xfer(1, REG_CTRL, 32'h0000_0030);
    repeat (5) @(posedge i_clk);
    chk("soaking", 32'(SVC_SOAKING), 32'(svc));
    for (n = 0; n < 200 && svc !== SVC_IN_SERVICE; n++) @(posedge i_clk);
    tmo(n);
    chk("soak_time", 32'h1, 32'(n >= 10));
    xfer(1, REG_AUTH_THR, 32'h0000_0002);
    xfer(1, REG_CTRL, 32'h0000_0100);
    cpa_link_model_inst.set_link(0, 0, 1);
    cpa_link_model_inst.pulse(0, 5);
    wait_alarm();
    // Align to a window end: the alarm drops at one
    for (n = 0; n < 200 && alarm !== 1'b0; n++) @(posedge i_clk);
    tmo(n);
    cpa_link_model_inst.pulse(0, 2);
    repeat (60) @(posedge i_clk);
    chk("alarm_at_thr", 32'h0, 32'(alarm));
    cpa_link_model_inst.pulse(0, 5);
    wait_alarm();
    cpa_link_model_inst.set_link(0, 0, 0);
    repeat (6) @(posedge i_clk);
    chk("alarm_one_end", 32'h0, 32'(alarm));
    cpa_link_model_inst.pulse(1, 3);
    xfer(0, REG_SEQ_MISMATCH_CNT, 0); chk("seq", 32'h0000_0003, q);
    give_verdict();
  end
endmodule : tb_top

// file: src/cpa_pkg.sv
/*
  Package for the client port alarm control block: register map, field
  layouts, reset values and timing constants.
  Assumes a 125 MHz system clock and a classic Wishbone register bus.
*/
package cpa_pkg;

  localparam int unsigned CLK_HZ = 125_000_000;

  // Register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_SOAK = 8'h04;
  localparam logic [7:0] REG_MAX_FRAME = 8'h08;
  localparam logic [7:0] REG_AUTH_THR = 8'h0C;
  localparam logic [7:0] REG_STATE = 8'h10;
  localparam logic [7:0] REG_OVERSIZE_CNT = 8'h14;
  localparam logic [7:0] REG_SEQ_MISMATCH_CNT = 8'h18;
  localparam logic [7:0] REG_AUTH_ERR_CNT = 8'h1C;
  localparam logic [7:0] REG_IRQ_STATUS = 8'h20;
  localparam logic [7:0] REG_IRQ_ENABLE = 8'h24;
  localparam logic [7:0] REG_IRQ_CLEAR = 8'h28;

  // Control register fields
  localparam int CTRL_SHUTDOWN_MODE_LSB = 0;
  localparam int CTRL_RESTART_BIT = 2;
  localparam int CTRL_ADMIN_LSB = 4;
  localparam int CTRL_NEAR_AUTH_BIT = 8;
  localparam int CTRL_FAR_AUTH_BIT = 9;

  // Interrupt bit positions
  localparam int IRQ_LASER_OFF = 0;
  localparam int IRQ_IN_SERVICE = 1;
  localparam int IRQ_OVERSIZE = 2;
  localparam int IRQ_AUTH_ALARM = 3;
  localparam int IRQ_SEQ_MISMATCH = 4;
  localparam int IRQ_W = 5;

  // Soak: 0..48 h in 15 minute steps
  localparam int unsigned SOAK_STEP_MIN = 15;
  localparam int unsigned SOAK_MAX_HOURS = 48;
  localparam logic [7:0] SOAK_MAX_STEPS = 8'(SOAK_MAX_HOURS * 60 / SOAK_STEP_MIN);
  localparam longint unsigned SOAK_STEP_CYCLES =
    longint'(SOAK_STEP_MIN) * 60 * CLK_HZ;
  localparam logic [7:0] SOAK_RESET = 8'h00;

  // Frame size limits in bytes
  localparam logic [13:0] MAX_FRAME_MIN = 14'd64;
  localparam logic [13:0] MAX_FRAME_MAX = 14'd9700;
  localparam logic [13:0] MAX_FRAME_RESET = 14'd1548;

  // Authentication alarm
  localparam logic [8:0] AUTH_THR_MIN = 9'd1;
  localparam logic [8:0] AUTH_THR_MAX = 9'd500;
  localparam logic [8:0] AUTH_THR_RESET = 9'd1;
  localparam int unsigned AUTH_WINDOW_S = 10;
  localparam longint unsigned AUTH_WINDOW_CYCLES =
    longint'(AUTH_WINDOW_S) * CLK_HZ;

  localparam logic [31:0] CNT_RESET = 32'h0000_0000;

  typedef enum logic [1:0] {
    SHUTDOWN_DISABLED = 2'b00,
    SHUTDOWN_MANUAL = 2'b01,
    SHUTDOWN_MANUAL_TEST = 2'b10
  } cpa_shutdown_type;

  typedef enum logic [1:0] {
    ADMIN_IN_SERVICE = 2'b00,
    ADMIN_OUT_OF_SERVICE = 2'b01,
    ADMIN_MAINTENANCE = 2'b10,
    ADMIN_AUTO_IN_SERVICE = 2'b11
  } cpa_admin_type;

  typedef enum logic [1:0] {
    SVC_OUT_OF_SERVICE = 2'b00,
    SVC_SOAKING = 2'b01,
    SVC_IN_SERVICE = 2'b10
  } cpa_svc_type;

endpackage : cpa_pkg

// file: src/cpa_sync.sv
/*
  Two flip-flop synchroniser for one level from outside the clock domain.
  Assumes reset is already synchronous to i_clk on release.
*/
`timescale 1ns/1ps
module cpa_sync (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_d,
  output logic o_q
);
  typedef struct packed {
    logic meta;
    logic sync;
  } cpa_sync_type;

  cpa_sync_type s_q;
  cpa_sync_type s_d;

  always_comb begin
    s_d.meta = i_d;
    s_d.sync = s_q.meta;
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_q = s_q.sync;
endmodule : cpa_sync

// file: src/cpa_tick.sv
/*
  Free running period counter giving a one-cycle tick every PERIOD
  enabled cycles. Assumes PERIOD of at least one.
*/
`timescale 1ns/1ps
module cpa_tick #(
  parameter longint unsigned PERIOD = 64'd125_000_000
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic i_clear,
  output logic o_tick
);
  typedef struct packed {
    logic [39:0] cnt;
    logic tick;
  } cpa_tick_type;

  cpa_tick_type s_q;
  cpa_tick_type s_d;

  always_comb begin
    s_d = s_q;
    s_d.tick = 1'b0;
    if (i_clear) begin
      s_d.cnt = '0;
    end else if (s_q.cnt == 40'(PERIOD - 1)) begin
      s_d.cnt = '0;
      s_d.tick = 1'b1;
    end else begin
      s_d.cnt = s_q.cnt + 40'd1;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_q <= '0;
    end else if (i_ce) begin
      s_q <= s_d;
    end
  end

  assign o_tick = s_q.tick;
endmodule : cpa_tick

// file: src/cpa_top.sv
/*
  Client port control and alarm logic: laser shutdown, in-service soak,
  frame size check, payload authentication alarm and sequence mismatch
  counting, with a classic Wishbone register slave and one interrupt.
  Assumes frame and event strobes come from logic on i_clk; the loss of
  signal and peer authentication levels come from pins.
// Summary of operation
// (R01) With shutdown disabled, the default, the laser stays on always.
// (R02) In manual restart mode, outage or loss of signal turns laser off.
// (R03) After such a shutdown the laser stays off until a restart command.
// (R04) A test restart command turns the laser back on while shut down.
// (R05) While soaking, continuous valid input for the soak time gives IS.
// (R06) The soak time is 0 to 48 hours in 15 minute steps.
// (R07) Frames above the programmed size, 64 to 9700 default 1548, fail.
// (R08) Software locks the port before changing the maximum frame size.
// (R09) The auth alarm threshold is 1 to 500 and resets to 1.
// (R10) Auth alarm rises when errors in a 10 second window exceed it.
// (R11) Auth alarm is suppressed unless auth is enabled at both ends.
// (R12) Each packet sequence number mismatch is counted per port.
// (R13) Oversize frames are discarded and counted.
*/
`timescale 1ns/1ps
module cpa_top
  import cpa_pkg::*;
#(
  parameter longint unsigned SOAK_STEP_CYC = cpa_pkg::SOAK_STEP_CYCLES,
  parameter longint unsigned AUTH_WIN_CYC = cpa_pkg::AUTH_WINDOW_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  // Wishbone classic slave
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  // Client link status
  input wire logic i_loss_of_input_signal,
  input wire logic i_traffic_outage,
  input wire logic i_far_auth_enable,
  // Frame check, same clock domain
  input wire logic i_frame_end,
  input wire logic [13:0] i_frame_len,
  output logic o_frame_accept,
  output logic o_frame_discard,
  // Encryption events, same clock domain
  input wire logic i_auth_error,
  input wire logic i_packet_sequence_number_mismatch,
  // Outputs
  output logic o_laser_on,
  output cpa_pkg::cpa_svc_type o_service_state,
  output logic o_auth_alarm,
  output logic o_irq
);
  import cpa_pkg::*;

  typedef struct packed {
    cpa_shutdown_type shutdown_mode;
    cpa_admin_type admin;
    logic near_auth;
    logic [7:0] soak_steps;
    logic [13:0] max_frame;
    logic [8:0] auth_thr;
    logic laser_off;
    cpa_svc_type svc;
    logic [7:0] soak_cnt;
    logic [31:0] oversize_cnt;
    logic [31:0] seq_cnt;
    logic [31:0] auth_win_cnt;
    logic [31:0] auth_last_cnt;
    logic auth_alarm;
    logic [IRQ_W-1:0] irq_status;
    logic [IRQ_W-1:0] irq_enable;
    logic [31:0] rd_dat;
    logic ack;
    logic frame_accept;
    logic frame_discard;
  } cpa_state_type;

  cpa_state_type s_q;
  cpa_state_type s_d;
  // Reset sync kept apart, it has its own reset
  logic [1:0] rst_sync_q;
  logic rst_n_int;
  logic los_s;
  logic outage_s;
  logic far_auth_s;
  logic soak_tick;
  logic auth_tick;
  logic soak_clear;
  logic wb_req;
  logic wb_wr;
  logic [IRQ_W-1:0] irq_set;
  logic [IRQ_W-1:0] irq_clr;
  logic signal_bad;

  // Reset release through two flops
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n_int = rst_sync_q[1];

  cpa_sync u_sync_los (
    .i_clk(i_clk),
    .i_rst_n(rst_n_int),
    .i_d(i_loss_of_input_signal),
    .o_q(los_s)
  );
  cpa_sync u_sync_outage (
    .i_clk(i_clk),
    .i_rst_n(rst_n_int),
    .i_d(i_traffic_outage),
    .o_q(outage_s)
  );
  cpa_sync u_sync_far (
    .i_clk(i_clk),
    .i_rst_n(rst_n_int),
    .i_d(i_far_auth_enable),
    .o_q(far_auth_s)
  );

  cpa_tick #(.PERIOD(SOAK_STEP_CYC)) u_soak_tick (
    .i_clk(i_clk),
    .i_rst_n(rst_n_int),
    .i_ce(i_ce),
    .i_clear(soak_clear),
    .o_tick(soak_tick)
  );
  cpa_tick #(.PERIOD(AUTH_WIN_CYC)) u_auth_tick (
    .i_clk(i_clk),
    .i_rst_n(rst_n_int),
    .i_ce(i_ce),
    .i_clear(1'b0),
    .o_tick(auth_tick)
  );

  assign signal_bad = los_s | outage_s;
  assign soak_clear = signal_bad || s_q.svc != SVC_SOAKING;
  assign wb_req = i_wb_cyc && i_wb_stb && !s_q.ack;
  assign wb_wr = wb_req && i_wb_we;

  always_comb begin
    s_d = s_q;
    irq_set = '0;
    irq_clr = '0;
    s_d.ack = wb_req;
    s_d.frame_accept = 1'b0;
    s_d.frame_discard = 1'b0;

    // Register writes per byte lane; max frame and auth threshold need lanes 0 and 1 both
    if (wb_wr) begin
      case (i_wb_adr)
        REG_CTRL: begin
          if (i_wb_sel[0]) begin
            s_d.shutdown_mode =
              cpa_shutdown_type'(i_wb_dat[CTRL_SHUTDOWN_MODE_LSB +: 2]);
            s_d.admin = cpa_admin_type'(i_wb_dat[CTRL_ADMIN_LSB +: 2]);
            // (R03) Explicit restart
            if (i_wb_dat[CTRL_RESTART_BIT]) begin
              s_d.laser_off = 1'b0;
            end
          end
          if (i_wb_sel[1]) begin
            s_d.near_auth = i_wb_dat[CTRL_NEAR_AUTH_BIT];
          end
        end
        REG_SOAK: begin
          // (R06) Clamp to 48 hours
          if (i_wb_sel[0]) begin
            s_d.soak_steps = (i_wb_dat[7:0] > SOAK_MAX_STEPS) ?
              SOAK_MAX_STEPS : i_wb_dat[7:0];
          end
        end
        REG_MAX_FRAME: begin
          // (R08) Only while locked
          if (&i_wb_sel[1:0] && s_q.admin == ADMIN_OUT_OF_SERVICE) begin
            // (R07) Clamp into range
            if (i_wb_dat[13:0] < MAX_FRAME_MIN) begin
              s_d.max_frame = MAX_FRAME_MIN;
            end else if (i_wb_dat[13:0] > MAX_FRAME_MAX) begin
              s_d.max_frame = MAX_FRAME_MAX;
            end else begin
              s_d.max_frame = i_wb_dat[13:0];
            end
          end
        end
        REG_AUTH_THR: begin
          // (R09) Clamp 1..500
          if (&i_wb_sel[1:0]) begin
            if (i_wb_dat[15:0] > 16'(AUTH_THR_MAX)) begin
              s_d.auth_thr = AUTH_THR_MAX;
            end else if (i_wb_dat[8:0] < AUTH_THR_MIN) begin
              s_d.auth_thr = AUTH_THR_MIN;
            end else begin
              s_d.auth_thr = i_wb_dat[8:0];
            end
          end
        end
        REG_IRQ_ENABLE: begin
          if (i_wb_sel[0]) begin
            s_d.irq_enable = i_wb_dat[IRQ_W-1:0];
          end
        end
        REG_IRQ_CLEAR: begin
          if (i_wb_sel[0]) begin
            irq_clr = i_wb_dat[IRQ_W-1:0];
          end
        end
        default: begin
        end
      endcase
    end

    // Laser control
    case (s_q.shutdown_mode)
      SHUTDOWN_MANUAL: begin
        // (R02) Shut down on outage
        if (signal_bad && !s_q.laser_off) begin
          s_d.laser_off = 1'b1;
          irq_set[IRQ_LASER_OFF] = 1'b1;
        end
      end
      SHUTDOWN_MANUAL_TEST: begin
        // (R04) Test restart
        s_d.laser_off = 1'b0;
      end
      SHUTDOWN_DISABLED: begin
        // (R01) Laser kept on
        s_d.laser_off = 1'b0;
      end
      default: begin
        s_d.laser_off = 1'b0;
      end
    endcase

    // Service state
    case (s_q.admin)
      ADMIN_AUTO_IN_SERVICE: begin
        case (s_q.svc)
          SVC_IN_SERVICE: begin
            s_d.svc = SVC_IN_SERVICE;
          end
          SVC_SOAKING: begin
            // (R05) Soak complete
            if (signal_bad) begin
              s_d.soak_cnt = '0;
            end else if (s_q.soak_cnt >= s_q.soak_steps) begin
              s_d.svc = SVC_IN_SERVICE;
              irq_set[IRQ_IN_SERVICE] = 1'b1;
            end else if (soak_tick) begin
              s_d.soak_cnt = s_q.soak_cnt + 8'd1;
            end
          end
          default: begin
            s_d.svc = SVC_SOAKING;
            s_d.soak_cnt = '0;
          end
        endcase
      end
      ADMIN_IN_SERVICE: begin
        s_d.svc = SVC_IN_SERVICE;
      end
      default: begin
        s_d.svc = SVC_OUT_OF_SERVICE;
        s_d.soak_cnt = '0;
      end
    endcase

    // (R07) Size check per frame
    if (i_frame_end) begin
      if (i_frame_len > s_q.max_frame) begin
        // (R13) Discard and count
        s_d.frame_discard = 1'b1;
        s_d.oversize_cnt = s_q.oversize_cnt + 32'd1;
        irq_set[IRQ_OVERSIZE] = 1'b1;
      end else begin
        s_d.frame_accept = 1'b1;
      end
    end

    // (R12) Sequence mismatch count
    if (i_packet_sequence_number_mismatch) begin
      s_d.seq_cnt = s_q.seq_cnt + 32'd1;
      irq_set[IRQ_SEQ_MISMATCH] = 1'b1;
    end

    // (R10) Ten second window
    if (auth_tick) begin
      s_d.auth_last_cnt = s_q.auth_win_cnt + {31'd0, i_auth_error};
      s_d.auth_win_cnt = '0;
      // (R11) Both ends enabled only
      s_d.auth_alarm = s_q.near_auth && far_auth_s &&
        (s_d.auth_last_cnt > 32'(s_q.auth_thr));
      if (s_d.auth_alarm) begin
        irq_set[IRQ_AUTH_ALARM] = 1'b1;
      end
    end else if (i_auth_error && s_q.auth_win_cnt != 32'hFFFF_FFFF) begin
      s_d.auth_win_cnt = s_q.auth_win_cnt + 32'd1;
    end
    // (R11) Drop alarm if one end disables
    if (!(s_q.near_auth && far_auth_s)) begin
      s_d.auth_alarm = 1'b0;
    end

    // Set wins over clear
    s_d.irq_status = (s_q.irq_status & ~irq_clr) | irq_set;

    // Read data
    s_d.rd_dat = '0;
    if (wb_req && !i_wb_we) begin
      case (i_wb_adr)
        REG_CTRL: begin
          s_d.rd_dat[CTRL_SHUTDOWN_MODE_LSB +: 2] = s_q.shutdown_mode;
          s_d.rd_dat[CTRL_ADMIN_LSB +: 2] = s_q.admin;
          s_d.rd_dat[CTRL_NEAR_AUTH_BIT] = s_q.near_auth;
          s_d.rd_dat[CTRL_FAR_AUTH_BIT] = far_auth_s;
        end
        REG_SOAK: s_d.rd_dat[7:0] = s_q.soak_steps;
        REG_MAX_FRAME: s_d.rd_dat[13:0] = s_q.max_frame;
        REG_AUTH_THR: s_d.rd_dat[8:0] = s_q.auth_thr;
        REG_STATE: begin
          s_d.rd_dat[0] = ~s_q.laser_off;
          s_d.rd_dat[2:1] = s_q.svc;
          s_d.rd_dat[3] = s_q.auth_alarm;
          s_d.rd_dat[4] = los_s;
          s_d.rd_dat[5] = outage_s;
          s_d.rd_dat[15:8] = s_q.soak_cnt;
        end
        REG_OVERSIZE_CNT: s_d.rd_dat = s_q.oversize_cnt;
        REG_SEQ_MISMATCH_CNT: s_d.rd_dat = s_q.seq_cnt;
        REG_AUTH_ERR_CNT: s_d.rd_dat = s_q.auth_last_cnt;
        REG_IRQ_STATUS: s_d.rd_dat[IRQ_W-1:0] = s_q.irq_status;
        REG_IRQ_ENABLE: s_d.rd_dat[IRQ_W-1:0] = s_q.irq_enable;
        default: s_d.rd_dat = '0;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      s_q.shutdown_mode <= SHUTDOWN_DISABLED;
      s_q.admin <= ADMIN_OUT_OF_SERVICE;
      s_q.near_auth <= 1'b0;
      s_q.soak_steps <= SOAK_RESET;
      s_q.max_frame <= MAX_FRAME_RESET;
      s_q.auth_thr <= AUTH_THR_RESET;
      s_q.laser_off <= 1'b0;
      s_q.svc <= SVC_OUT_OF_SERVICE;
      s_q.soak_cnt <= '0;
      s_q.oversize_cnt <= CNT_RESET;
      s_q.seq_cnt <= CNT_RESET;
      s_q.auth_win_cnt <= CNT_RESET;
      s_q.auth_last_cnt <= CNT_RESET;
      s_q.auth_alarm <= 1'b0;
      s_q.irq_status <= '0;
      s_q.irq_enable <= '0;
      s_q.rd_dat <= '0;
      s_q.ack <= 1'b0;
      s_q.frame_accept <= 1'b0;
      s_q.frame_discard <= 1'b0;
    end else if (i_ce) begin
      s_q.shutdown_mode <= s_d.shutdown_mode;
      s_q.admin <= s_d.admin;
      s_q.near_auth <= s_d.near_auth;
      s_q.soak_steps <= s_d.soak_steps;
      s_q.max_frame <= s_d.max_frame;
      s_q.auth_thr <= s_d.auth_thr;
      s_q.laser_off <= s_d.laser_off;
      s_q.svc <= s_d.svc;
      s_q.soak_cnt <= s_d.soak_cnt;
      s_q.oversize_cnt <= s_d.oversize_cnt;
      s_q.seq_cnt <= s_d.seq_cnt;
      s_q.auth_win_cnt <= s_d.auth_win_cnt;
      s_q.auth_last_cnt <= s_d.auth_last_cnt;
      s_q.auth_alarm <= s_d.auth_alarm;
      s_q.irq_status <= s_d.irq_status;
      s_q.irq_enable <= s_d.irq_enable;
      s_q.rd_dat <= s_d.rd_dat;
      s_q.ack <= s_d.ack;
      s_q.frame_accept <= s_d.frame_accept;
      s_q.frame_discard <= s_d.frame_discard;
    end
  end

  assign o_wb_dat = s_q.rd_dat;
  assign o_wb_ack = s_q.ack;
  assign o_laser_on = ~s_q.laser_off;
  assign o_service_state = s_q.svc;
  assign o_auth_alarm = s_q.auth_alarm;
  assign o_frame_accept = s_q.frame_accept;
  assign o_frame_discard = s_q.frame_discard;
  assign o_irq = |(s_q.irq_status & s_q.irq_enable);
endmodule : cpa_top
